// file: pdm_pkg.sv
package pdm_pkg;

  localparam int PDM_PINS = 8;
  localparam int PDM_AW = 4;
  localparam int PDM_DW = 32;
  localparam int PDM_WAKE_SRCS = 7;

  // Word offsets of the register window (byte address = 4 * index)
  localparam logic [PDM_AW-1:0] PDM_REG_SEL0 = 4'h0;
  localparam logic [PDM_AW-1:0] PDM_REG_SEL1 = 4'h1;
  localparam logic [PDM_AW-1:0] PDM_REG_SEL2 = 4'h2;
  localparam logic [PDM_AW-1:0] PDM_REG_OUT_VALUE = 4'h3;
  localparam logic [PDM_AW-1:0] PDM_REG_OUT_ROUTE = 4'h4;
  localparam logic [PDM_AW-1:0] PDM_REG_IN_ROUTE = 4'h5;
  localparam logic [PDM_AW-1:0] PDM_REG_PIN_STATE = 4'h6;
  localparam logic [PDM_AW-1:0] PDM_REG_WAKE_EN = 4'h7;
  localparam logic [PDM_AW-1:0] PDM_REG_POWER = 4'h8;
  localparam logic [PDM_AW-1:0] PDM_REG_WAKE_CAUSE = 4'h9;

  // Wakeup source bit positions
  localparam int PDM_WK_PERIPH = 0;
  localparam int PDM_WK_SUPERVISOR = 1;
  localparam int PDM_WK_TIMEWHEEL = 2;
  localparam int PDM_WK_IO = 3;
  localparam int PDM_WK_EXT_RESET = 4;
  localparam int PDM_WK_WATCHDOG = 5;
  localparam int PDM_WK_PRECISION = 6;

  // Drive select codes
  localparam logic [2:0] PDM_DM_ANALOG_Z = 3'h0;
  localparam logic [2:0] PDM_DM_DIGITAL_Z = 3'h1;
  localparam logic [2:0] PDM_DM_PULLUP = 3'h2;
  localparam logic [2:0] PDM_DM_PULLDOWN = 3'h3;
  localparam logic [2:0] PDM_DM_OPEN_LOW = 3'h4;
  localparam logic [2:0] PDM_DM_OPEN_HIGH = 3'h5;
  localparam logic [2:0] PDM_DM_STRONG = 3'h6;
  localparam logic [2:0] PDM_DM_PULL_BOTH = 3'h7;

  // Reset values
  localparam logic [PDM_PINS-1:0] PDM_OUT_VALUE_RST = 8'h00;
  localparam logic [PDM_PINS-1:0] PDM_ROUTE_RST = 8'h00;
  localparam logic [PDM_WAKE_SRCS-1:0] PDM_WAKE_EN_RST = 7'h70;
  localparam logic [PDM_DW-1:0] PDM_READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PDM_PM_ACTIVE,
    PDM_PM_ALT_ACTIVE,
    PDM_PM_SLEEP,
    PDM_PM_HIBERNATE
  } pdm_power_t;

endpackage

// file: pdm_pin_drive.sv
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Every pin has its own three-bit drive select that picks one of eight driver setups.
// - Codes 0 and 1 leave the pin undriven, code 6 drives it strongly to the output value.
// - Code 2 pulls up or drives low, code 3 drives high or pulls down, code 7 pulls up for a 1 and down for a 0.
// - Code 4 drives strongly low for a 0 and releases the pin for a 1.
// - Code 5 drives strongly high for a 1 and releases the pin for a 0.
// - The driven value comes from the logic array when output routing is on, else the port bit.
// - The pin level always reaches pin state, and the logic array only when input routing is on.
// - Any enabled wakeup event, interrupt or reset, returns the power state to active.
// - Wakeup sources are peripheral, supervisor, timewheel and I/O interrupts plus three resets.
// - At reset a two-bit per-port field makes every pin analog or digital high-Z, driven low (10b) or pulled down (11b).
module pdm_pin_drive
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [PDM_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [PDM_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [PDM_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] port_reset_drive_select,
  input wire logic [PDM_PINS-1:0] programmable_logic_array_out,
  output logic [PDM_PINS-1:0] programmable_logic_array_in,
  input wire logic [PDM_PINS-1:0] pad_in,
  output logic [PDM_PINS-1:0] pad_out,
  output logic [PDM_PINS-1:0] pad_oe,
  output logic [PDM_PINS-1:0] pad_pullup_en,
  output logic [PDM_PINS-1:0] pad_pulldown_en,
  output logic [PDM_PINS-1:0] pad_analog_en,
  input wire logic periph_irq,
  input wire logic supervisor_irq,
  input wire logic timewheel_irq,
  input wire logic io_irq,
  input wire logic external_reset_pin,
  input wire logic watchdog_reset,
  input wire logic precision_reset,
  output logic [1:0] power_mode
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [PDM_PINS-1:0] drive_select_bit0_r;
  logic [PDM_PINS-1:0] drive_select_bit0_nxt;
  logic [PDM_PINS-1:0] drive_select_bit1_r;
  logic [PDM_PINS-1:0] drive_select_bit1_nxt;
  logic [PDM_PINS-1:0] drive_select_bit2_r;
  logic [PDM_PINS-1:0] drive_select_bit2_nxt;
  logic [PDM_PINS-1:0] port_output_value_r;
  logic [PDM_PINS-1:0] port_output_value_nxt;
  logic [PDM_PINS-1:0] out_route_r;
  logic [PDM_PINS-1:0] out_route_nxt;
  logic [PDM_PINS-1:0] in_route_r;
  logic [PDM_PINS-1:0] in_route_nxt;
  logic [PDM_WAKE_SRCS-1:0] wake_en_r;
  logic [PDM_WAKE_SRCS-1:0] wake_en_nxt;
  logic [PDM_WAKE_SRCS-1:0] wake_cause_r;
  logic [PDM_WAKE_SRCS-1:0] wake_cause_nxt;
  pdm_power_t power_r;
  pdm_power_t power_nxt;
  logic waitreq_r;
  logic waitreq_nxt;
  logic [PDM_DW-1:0] rdata_r;
  logic [PDM_DW-1:0] rdata_nxt;

  logic req;
  logic wr_take;
  logic [PDM_WAKE_SRCS-1:0] wake_src;
  logic [PDM_WAKE_SRCS-1:0] wake_hit;

  // ==========================================================================
  // Synchronisers for pins and other asynchronous inputs
  // ==========================================================================
  logic [PDM_PINS-1:0] pad_meta_r;
  logic [PDM_PINS-1:0] pin_state_r;
  logic [1:0] async_meta_r;
  logic [1:0] async_sync_r;

  // Same-domain wake sources skip these flops to keep wake latency short
  always_ff @(posedge clk)
  begin
    pad_meta_r <= pad_in;
    pin_state_r <= pad_meta_r;
    async_meta_r <= {external_reset_pin, io_irq};
    async_sync_r <= async_meta_r;
  end

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // One wait cycle per access: waitrequest drops for exactly one cycle
  assign req = avs_read | avs_write;
  // Only lane 0 gates writes: no register is wider than eight bits
  assign wr_take = avs_write & ~waitreq_r & avs_byteenable[0];

  always_comb
  begin
    wake_src = '0;
    wake_src[PDM_WK_PERIPH] = periph_irq;
    wake_src[PDM_WK_SUPERVISOR] = supervisor_irq;
    wake_src[PDM_WK_TIMEWHEEL] = timewheel_irq;
    wake_src[PDM_WK_IO] = async_sync_r[0];
    wake_src[PDM_WK_EXT_RESET] = async_sync_r[1];
    wake_src[PDM_WK_WATCHDOG] = watchdog_reset;
    wake_src[PDM_WK_PRECISION] = precision_reset;
    wake_hit = wake_src & wake_en_r;
  end

  // ==========================================================================
  // Register next state
  // ==========================================================================
  always_comb
  begin
    drive_select_bit0_nxt = drive_select_bit0_r;
    drive_select_bit1_nxt = drive_select_bit1_r;
    drive_select_bit2_nxt = drive_select_bit2_r;
    port_output_value_nxt = port_output_value_r;
    out_route_nxt = out_route_r;
    in_route_nxt = in_route_r;
    wake_en_nxt = wake_en_r;
    wake_cause_nxt = wake_cause_r;
    power_nxt = power_r;
    waitreq_nxt = ~(req & waitreq_r);
    rdata_nxt = PDM_READ_ZERO;
    if (wr_take)
    begin
      unique case (avs_address)
        PDM_REG_SEL0: drive_select_bit0_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_SEL1: drive_select_bit1_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_SEL2: drive_select_bit2_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_OUT_VALUE: port_output_value_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_OUT_ROUTE: out_route_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_IN_ROUTE: in_route_nxt = avs_writedata[PDM_PINS-1:0];
        PDM_REG_WAKE_EN: wake_en_nxt = avs_writedata[PDM_WAKE_SRCS-1:0];
        PDM_REG_POWER: power_nxt = pdm_power_t'(avs_writedata[1:0]);
        PDM_REG_WAKE_CAUSE:
          wake_cause_nxt = wake_cause_r & ~avs_writedata[PDM_WAKE_SRCS-1:0];
        default: ;
      endcase
    end
    // A wake in the same cycle as a mode write or cause clear wins
    if (|wake_hit)
    begin
      power_nxt = PDM_PM_ACTIVE;
    end
    wake_cause_nxt = wake_cause_nxt | wake_hit;
    if (avs_read & waitreq_r)
    begin
      unique case (avs_address)
        PDM_REG_SEL0: rdata_nxt[PDM_PINS-1:0] = drive_select_bit0_r;
        PDM_REG_SEL1: rdata_nxt[PDM_PINS-1:0] = drive_select_bit1_r;
        PDM_REG_SEL2: rdata_nxt[PDM_PINS-1:0] = drive_select_bit2_r;
        PDM_REG_OUT_VALUE: rdata_nxt[PDM_PINS-1:0] = port_output_value_r;
        PDM_REG_OUT_ROUTE: rdata_nxt[PDM_PINS-1:0] = out_route_r;
        PDM_REG_IN_ROUTE: rdata_nxt[PDM_PINS-1:0] = in_route_r;
        PDM_REG_PIN_STATE: rdata_nxt[PDM_PINS-1:0] = pin_state_r;
        PDM_REG_WAKE_EN: rdata_nxt[PDM_WAKE_SRCS-1:0] = wake_en_r;
        PDM_REG_POWER: rdata_nxt[1:0] = power_r;
        PDM_REG_WAKE_CAUSE: rdata_nxt[PDM_WAKE_SRCS-1:0] = wake_cause_r;
        default: rdata_nxt = PDM_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Reset field maps straight onto codes 0..3
      // Port bit resets to 0, so field 10b drives pins low until firmware sets it
      drive_select_bit0_r <= {PDM_PINS{port_reset_drive_select[0]}};
      drive_select_bit1_r <= {PDM_PINS{port_reset_drive_select[1]}};
      drive_select_bit2_r <= '0;
      port_output_value_r <= PDM_OUT_VALUE_RST;
      out_route_r <= PDM_ROUTE_RST;
      in_route_r <= PDM_ROUTE_RST;
      // Reset sources wake by default; interrupts wait for firmware to enable them
      wake_en_r <= PDM_WAKE_EN_RST;
      wake_cause_r <= '0;
      power_r <= PDM_PM_ACTIVE;
      waitreq_r <= 1'b1;
      rdata_r <= PDM_READ_ZERO;
    end
    else
    begin
      drive_select_bit0_r <= drive_select_bit0_nxt;
      drive_select_bit1_r <= drive_select_bit1_nxt;
      drive_select_bit2_r <= drive_select_bit2_nxt;
      port_output_value_r <= port_output_value_nxt;
      out_route_r <= out_route_nxt;
      in_route_r <= in_route_nxt;
      wake_en_r <= wake_en_nxt;
      wake_cause_r <= wake_cause_nxt;
      power_r <= power_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;
  // Power state is only recorded here; clocks and regulators are steered elsewhere
  assign power_mode = power_r;

  // ==========================================================================
  // Per-pin driver decode
  // ==========================================================================
  // Pads see one cycle of latency from any register or routing change
  genvar gi;
  generate
    for (gi = 0; gi < PDM_PINS; gi++)
    begin : g_pin
      logic [2:0] sel;
      logic val;
      logic out_nxt;
      logic oe_nxt;
      logic pu_nxt;
      logic pd_nxt;
      logic an_nxt;
      logic lai_nxt;
      logic out_r;
      logic oe_r;
      logic pu_r;
      logic pd_r;
      logic an_r;
      logic lai_r;

      always_comb
      begin
        sel = {drive_select_bit2_r[gi], drive_select_bit1_r[gi], drive_select_bit0_r[gi]};
        val = out_route_r[gi] ? programmable_logic_array_out[gi]
                              : port_output_value_r[gi];
        out_nxt = val;
        oe_nxt = 1'b0;
        pu_nxt = 1'b0;
        pd_nxt = 1'b0;
        an_nxt = 1'b0;
        unique case (sel)
          PDM_DM_ANALOG_Z: an_nxt = 1'b1;
          PDM_DM_DIGITAL_Z: oe_nxt = 1'b0;
          PDM_DM_PULLUP:
          begin
            oe_nxt = ~val;
            pu_nxt = val;
          end
          PDM_DM_PULLDOWN:
          begin
            oe_nxt = val;
            pd_nxt = ~val;
          end
          PDM_DM_OPEN_LOW: oe_nxt = ~val;
          PDM_DM_OPEN_HIGH: oe_nxt = val;
          PDM_DM_STRONG: oe_nxt = 1'b1;
          PDM_DM_PULL_BOTH:
          begin
            pu_nxt = val;
            pd_nxt = ~val;
          end
        endcase
        lai_nxt = pin_state_r[gi] & in_route_r[gi];
      end

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          // Pads stay released during reset; the reset mode shows one edge after release
          out_r <= 1'b0;
          oe_r <= 1'b0;
          pu_r <= 1'b0;
          pd_r <= 1'b0;
          an_r <= 1'b0;
          lai_r <= 1'b0;
        end
        else
        begin
          out_r <= out_nxt;
          oe_r <= oe_nxt;
          pu_r <= pu_nxt;
          pd_r <= pd_nxt;
          an_r <= an_nxt;
          lai_r <= lai_nxt;
        end
      end

      assign pad_out[gi] = out_r;
      assign pad_oe[gi] = oe_r;
      assign pad_pullup_en[gi] = pu_r;
      assign pad_pulldown_en[gi] = pd_r;
      assign pad_analog_en[gi] = an_r;
      assign programmable_logic_array_in[gi] = lai_r;
    end
  endgenerate

endmodule // pdm_pin_drive

`default_nettype wire

// file: pdm_pin_drive_props.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Pin driver properties
module pdm_pin_drive_props
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [1:0] port_reset_drive_select,
  input wire logic [PDM_PINS-1:0] programmable_logic_array_in,
  input wire logic [PDM_PINS-1:0] pad_in,
  input wire logic [PDM_PINS-1:0] pad_oe,
  input wire logic [PDM_PINS-1:0] pad_pullup_en,
  input wire logic [PDM_PINS-1:0] pad_pulldown_en,
  input wire logic [PDM_PINS-1:0] pad_analog_en,
  input wire logic external_reset_pin,
  input wire logic watchdog_reset,
  input wire logic precision_reset,
  input wire logic [1:0] power_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer");
  property p_z;
    (pad_analog_en & (pad_oe | pad_pullup_en | pad_pulldown_en)) == '0;
  endproperty
  a_z: assert property (p_z) else $error("analog pin driven");
  property p_pull;
    (pad_pullup_en & pad_pulldown_en) == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("both pulls on");
  property p_oe;
    (pad_oe & (pad_pullup_en | pad_pulldown_en)) == '0;
  endproperty
  a_oe: assert property (p_oe) else $error("pull with strong drive");
  property p_sync;
    (programmable_logic_array_in & ~$past(pad_in, 3)) == '0;
  endproperty
  a_sync: assert property (p_sync) else $error("routed input early");
  property p_wake;
    watchdog_reset || precision_reset |=> power_mode == PDM_PM_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_wake_ext;
    external_reset_pin [*4] |=> power_mode == PDM_PM_ACTIVE;
  endproperty
  a_wake_ext: assert property (p_wake_ext) else $error("no pin wake");
  property p_rst_mode;
    $fell(sys_rst) && port_reset_drive_select == 2'h3 |=> pad_pulldown_en == '1;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("reset mode wrong");
  c_wake: cover property (precision_reset ##1 power_mode == PDM_PM_ACTIVE);
  c_route: cover property (programmable_logic_array_in != '0);
  c_rst: cover property ($fell(sys_rst) && port_reset_drive_select == 2'h3);
endmodule // pdm_pin_drive_props
`default_nettype wire

// file: pdm_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Pin loads
module pdm_pad_model
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic [PDM_PINS-1:0] pad_out,
  input wire logic [PDM_PINS-1:0] pad_oe,
  input wire logic [PDM_PINS-1:0] pad_pullup_en,
  input wire logic [PDM_PINS-1:0] pad_pulldown_en,
  input wire logic [PDM_PINS-1:0] ext_en,
  input wire logic [PDM_PINS-1:0] ext_lvl,
  output logic [PDM_PINS-1:0] pad_in
);
  logic [PDM_PINS-1:0] flt_r = '0;
  // Undriven pins wander so no check leans on a stale level
  always @(posedge clk) flt_r <= ~flt_r;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl)
    | (~pad_oe & ~ext_en & (pad_pullup_en | (~pad_pulldown_en & flt_r)));
endmodule // pdm_pad_model
`default_nettype wire

// file: pdm_pin_drive_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench
module pdm_pin_drive_tb_top
  import pdm_pkg::*;
;
  localparam logic [15:0][4:0] MODE_EXP = {5'h02, 5'h01, 5'h0c, 5'h08, 5'h0c, 5'h00,
    5'h00, 5'h08, 5'h0c, 5'h01, 5'h02, 5'h08, 5'h00, 5'h00, 5'h10, 5'h10};
  localparam logic [3:0][31:0] RST_EXP = {32'h000000ff, 32'h00ff0000, 32'h0, 32'hff000000};
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [PDM_AW-1:0] avs_address;
  logic [PDM_DW-1:0] avs_writedata, avs_readdata, rdata;
  logic [1:0] port_reset_drive_select, power_mode;
  logic [PDM_PINS-1:0] programmable_logic_array_out, programmable_logic_array_in, pad_in;
  logic [PDM_PINS-1:0] pad_out, pad_oe, pad_pullup_en, pad_pulldown_en, pad_analog_en;
  logic [PDM_PINS-1:0] ext_en, ext_lvl;
  logic [3:0] avs_byteenable;
  logic [PDM_WAKE_SRCS-1:0] wake_src;
  int mismatches = 0;
  int check_count = 0;
  pdm_pin_drive dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_reset_drive_select,
    .programmable_logic_array_out, .programmable_logic_array_in, .pad_in, .pad_out, .pad_oe,
    .pad_pullup_en, .pad_pulldown_en, .pad_analog_en, .periph_irq(wake_src[PDM_WK_PERIPH]),
    .supervisor_irq(wake_src[PDM_WK_SUPERVISOR]), .timewheel_irq(wake_src[PDM_WK_TIMEWHEEL]),
    .io_irq(wake_src[PDM_WK_IO]), .external_reset_pin(wake_src[PDM_WK_EXT_RESET]),
    .watchdog_reset(wake_src[PDM_WK_WATCHDOG]), .precision_reset(wake_src[PDM_WK_PRECISION]),
    .power_mode);
  pdm_pad_model pad_u (.clk, .pad_out, .pad_oe, .pad_pullup_en, .pad_pulldown_en, .ext_en,
    .ext_lvl, .pad_in);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask
  // Holds the request until waitrequest is seen low, then leaves one idle edge
  task automatic bus(input logic w, input logic [PDM_AW-1:0] a, input logic [PDM_DW-1:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      results();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rst(input logic [1:0] f);
    port_reset_drive_select <= f;
    sys_rst <= 1'b1;
    cyc(4);
    sys_rst <= 1'b0;
    cyc(2);
  endtask
  function automatic logic [31:0] pin(input int i);
    return {27'h0, pad_analog_en[i], pad_oe[i], pad_oe[i] & pad_out[i], pad_pullup_en[i],
      pad_pulldown_en[i]};
  endfunction
  initial
  begin
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    avs_byteenable <= 4'hf;
    programmable_logic_array_out <= 8'h5a;
    {ext_en, ext_lvl, wake_src} <= '0;
    for (int f = 0; f < 4; f++)
    begin
      rst(f[1:0]);
      chk("reset mode", RST_EXP[f], {pad_analog_en, pad_oe, pad_pullup_en, pad_pulldown_en});
    end
    for (int c = 0; c < 8; c++)
      for (int v = 0; v < 2; v++)
      begin
        bus(1'b1, PDM_REG_SEL0, c[0] ? 32'h7f : 32'h80);
        bus(1'b1, PDM_REG_SEL1, c[1] ? 32'hff : 32'h00);
        bus(1'b1, PDM_REG_SEL2, c[2] ? 32'hff : 32'h00);
        bus(1'b1, PDM_REG_OUT_VALUE, v[0] ? 32'hff : 32'h00);
        cyc(1);
        chk("pin0", {27'h0, MODE_EXP[{c[2:0], v[0]}]}, pin(0));
        chk("pin7", {27'h0, MODE_EXP[{c[2:1], ~c[0], v[0]}]}, pin(7));
      end
    bus(1'b1, PDM_REG_SEL0, 32'h0);
    bus(1'b1, PDM_REG_OUT_VALUE, 32'h0f);
    bus(1'b1, PDM_REG_OUT_ROUTE, 32'hff);
    cyc(1);
    chk("routed out", 32'h5a, {24'h0, pad_out});
    bus(1'b1, PDM_REG_OUT_ROUTE, 32'h0);
    cyc(1);
    chk("port out", 32'h0f, {24'h0, pad_out});
    bus(1'b1, PDM_REG_SEL0, 32'hff);
    bus(1'b1, PDM_REG_SEL1, 32'h0);
    bus(1'b1, PDM_REG_SEL2, 32'h0);
    ext_en <= 8'hff;
    ext_lvl <= 8'hc3;
    bus(1'b1, PDM_REG_IN_ROUTE, 32'h0f);
    cyc(4);
    bus(1'b0, PDM_REG_PIN_STATE, 32'h0);
    chk("pin state", 32'hc3, rdata);
    chk("routed in", 32'h03, {24'h0, programmable_logic_array_in});
    bus(1'b1, PDM_REG_WAKE_EN, 32'h7f);
    bus(1'b1, PDM_REG_WAKE_CAUSE, 32'h7f);
    for (int i = 0; i < PDM_WAKE_SRCS; i++)
    begin
      bus(1'b1, PDM_REG_POWER, 32'h2);
      chk("sleep", 32'h2, {30'h0, power_mode});
      wake_src <= 7'h1 << i;
      cyc(4);
      wake_src <= '0;
      chk("woken", 32'h0, {30'h0, power_mode});
      bus(1'b0, PDM_REG_WAKE_CAUSE, 32'h0);
      chk("cause", 32'h1 << i, rdata);
      bus(1'b1, PDM_REG_WAKE_CAUSE, 32'h1 << i);
    end
    bus(1'b1, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rdata);
    bus(1'b1, PDM_REG_OUT_VALUE, 32'h3c);
    avs_byteenable <= 4'h0;
    bus(1'b1, PDM_REG_OUT_VALUE, 32'hff);
    avs_byteenable <= 4'hf;
    bus(1'b0, PDM_REG_OUT_VALUE, 32'h0);
    chk("lane off", 32'h3c, rdata);
    bus(1'b1, PDM_REG_WAKE_EN, 32'h70);
    bus(1'b1, PDM_REG_POWER, 32'h2);
    wake_src <= 7'h1;
    cyc(4);
    wake_src <= '0;
    chk("masked wake", 32'h2, {30'h0, power_mode});
    bus(1'b0, PDM_REG_WAKE_CAUSE, 32'h0);
    chk("masked cause", 32'h0, rdata);
    results();
  end
endmodule // pdm_pin_drive_tb_top
bind pdm_pin_drive pdm_pin_drive_props props_u (.clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .port_reset_drive_select, .programmable_logic_array_in, .pad_in, .pad_oe,
  .pad_pullup_en, .pad_pulldown_en, .pad_analog_en, .external_reset_pin, .watchdog_reset,
  .precision_reset, .power_mode);
`default_nettype wire
